// ===== rtl/bpsc_params.svh
// Constants for the bus pin state controller.
// Assumes inclusion by bare name from the rtl folder.
`ifndef BPSC_PARAMS_SVH
`define BPSC_PARAMS_SVH
`define BPSC_ADDR_W      26
`define BPSC_DATA_LO_W   16
`define BPSC_DATA_HI_W   16
`define BPSC_ROMCS_W     4
`define BPSC_RAS_W       4
`define BPSC_LEVEL_LOW   1'b0
`define BPSC_LEVEL_HIGH  1'b1
`define BPSC_SYNC_RESET  3'h0
`define BPSC_SYNC_ARMED  3'h7
`endif

// ===== rtl/bpsc_pkg.sv
// Types for the bus pin state controller.
// Assumes no other package.
`default_nettype none
package bpsc_pkg;
	typedef enum logic [2:0] {
		BPSC_COND_NORMAL,
		BPSC_COND_CLKRST,
		BPSC_COND_SYSRST,
		BPSC_COND_SUSPEND,
		BPSC_COND_HIBERNATE,
		BPSC_COND_HOLD
	} bpsc_cond_t;
endpackage
`default_nettype wire

// ===== rtl/bpsc_top.sv
// Bus pin state controller: selects the system bus pin state per condition.
// Assumes core bus signals and mode inputs come from logic on mclk_i.
// Operation
// - address and low data: 0, hold, float
// - upper data: 0 or float, hold, float as data or hold as GPIO
// - chip selects float or high by condition
// - strobes float or high by condition
// - DRAM strobes high, low, float, source-dependent
// - bus clock low except during bus hold
// - reset output float, high, low, normal
// - retained pins keep last full-speed level
// - hold clock low from Suspend, else toggling
// - switch reset drives DRAM strobes low
// - normal pins keep functional behaviour
`include "bpsc_params.svh"
`default_nettype none
module bpsc_top
#(
	parameter int ADDR_W  = `BPSC_ADDR_W,
	parameter int DLO_W   = `BPSC_DATA_LO_W,
	parameter int DHI_W   = `BPSC_DATA_HI_W,
	parameter int ROMCS_W = `BPSC_ROMCS_W,
	parameter int RAS_W   = `BPSC_RAS_W
)
(
	// Clock and reset
	input  wire logic               mclk_i,
	input  wire logic               rst_n_i,
	// Condition inputs from the reset and power-mode controller
	input  wire logic               clock_domain_reset_i,
	input  wire logic               watchdog_reset_i,
	input  wire logic               reset_switch_input_i,
	input  wire logic               suspend_i,
	input  wire logic               hibernate_i,
	input  wire logic               power_down_timer_i,
	input  wire logic               bus_hold_i,
	input  wire logic               upper_is_data_i,
	// Core bus side in full-speed operation
	input  wire logic [ADDR_W-1:0]  core_addr_i,
	input  wire logic [DLO_W-1:0]   core_dlo_i,
	input  wire logic [DHI_W-1:0]   core_dhi_i,
	input  wire logic               core_data_oe_i,
	input  wire logic               core_display_sel_n_i,
	input  wire logic [ROMCS_W-1:0] core_boot_sel_n_i,
	input  wire logic [5:0]         core_strobes_n_i,
	input  wire logic [RAS_W-1:0]   core_row_n_i,
	input  wire logic [1:0]         core_col_n_i,
	input  wire logic               core_system_bus_clock_out_i,
	input  wire logic               core_rst_out_i,
	// Pin side
	output logic [ADDR_W-1:0]       addr_o,
	output logic                    addr_oe_o,
	output logic [DLO_W-1:0]        dlo_o,
	output logic                    dlo_oe_o,
	output logic [DHI_W-1:0]        dhi_o,
	output logic                    dhi_oe_o,
	output logic                    display_select_n_o,
	output logic                    display_select_oe_o,
	output logic [ROMCS_W-1:0]      boot_memory_select_n_o,
	output logic                    boot_memory_select_oe_o,
	output logic [5:0]              strobes_n_o,
	output logic                    strobes_oe_o,
	output logic [RAS_W-1:0]        dram_row_strobe_n_o,
	output logic                    dram_upper_col_strobe_n_o,
	output logic                    dram_lower_col_strobe_n_o,
	output logic                    dram_oe_o,
	output logic                    system_bus_clock_out_o,
	output logic                    reset_output_o,
	output logic                    reset_output_oe_o,
	output var bpsc_pkg::bpsc_cond_t cond_o
);
	localparam int NCOND = 7;

	typedef struct packed {
		logic [NCOND-1:0][2:0]  sync;
		logic [NCOND-1:0]       held;
		logic                   sw_src;
		logic                   hold_from_susp;
		bpsc_pkg::bpsc_cond_t   cond;
		logic [ADDR_W-1:0]      r_addr;
		logic [DLO_W-1:0]       r_dlo;
		logic [DHI_W-1:0]       r_dhi;
		logic                   r_doe;
		logic                   r_disp;
		logic [ROMCS_W-1:0]     r_boot;
		logic [5:0]             r_strb;
		logic [ADDR_W-1:0]      addr;
		logic                   addr_oe;
		logic [DLO_W-1:0]       dlo;
		logic                   dlo_oe;
		logic [DHI_W-1:0]       dhi;
		logic                   dhi_oe;
		logic                   disp;
		logic                   disp_oe;
		logic [ROMCS_W-1:0]     boot;
		logic                   boot_oe;
		logic [5:0]             strb;
		logic                   strb_oe;
		logic [RAS_W-1:0]       ras;
		logic [1:0]             cas;
		logic                   dram_oe;
		logic                   bclk;
		logic                   rout;
		logic                   rout_oe;
	} bpsc_state_t;

	bpsc_state_t state_reg;
	bpsc_state_t state_next;

	logic [NCOND-1:0] raw;
	logic [NCOND-1:0] lvl;
	assign raw = {bus_hold_i, power_down_timer_i, hibernate_i, suspend_i,
		reset_switch_input_i, watchdog_reset_i, clock_domain_reset_i};

	// A change counts once the second and third stages agree; until then the last level stands.
	always_comb
	begin
		for (int i = 0; i < NCOND; i++)
			lvl[i] = (state_reg.sync[i][1] == state_reg.sync[i][2]) ? state_reg.sync[i][2]
				: state_reg.held[i];
	end

	always_comb
	begin
		state_next = state_reg;
		for (int i = 0; i < NCOND; i++)
			state_next.sync[i] = {state_reg.sync[i][1:0], raw[i]};
		state_next.held = lvl;
		// Fixed priority keeps exactly one condition active.
		if (lvl[0])
			state_next.cond = bpsc_pkg::BPSC_COND_CLKRST;
		else if (lvl[1] | lvl[2])
			state_next.cond = bpsc_pkg::BPSC_COND_SYSRST;
		else if (lvl[4] | lvl[5])
			state_next.cond = bpsc_pkg::BPSC_COND_HIBERNATE;
		else if (lvl[6])
			state_next.cond = bpsc_pkg::BPSC_COND_HOLD;
		else if (lvl[3])
			state_next.cond = bpsc_pkg::BPSC_COND_SUSPEND;
		else
			state_next.cond = bpsc_pkg::BPSC_COND_NORMAL;
		// Switch reset wins the source when both resets are seen together.
		if (lvl[2])
			state_next.sw_src = 1'b1;
		else if (lvl[1])
			state_next.sw_src = 1'b0;
		if (state_reg.cond != bpsc_pkg::BPSC_COND_HOLD)
			state_next.hold_from_susp = (state_reg.cond == bpsc_pkg::BPSC_COND_SUSPEND);
		if (state_reg.cond == bpsc_pkg::BPSC_COND_NORMAL)
		begin
			state_next.r_addr = core_addr_i;
			state_next.r_dlo  = core_dlo_i;
			state_next.r_dhi  = core_dhi_i;
			state_next.r_doe  = core_data_oe_i;
			state_next.r_disp = core_display_sel_n_i;
			state_next.r_boot = core_boot_sel_n_i;
			state_next.r_strb = core_strobes_n_i;
		end
		case (state_next.cond)
			bpsc_pkg::BPSC_COND_CLKRST, bpsc_pkg::BPSC_COND_SYSRST,
			bpsc_pkg::BPSC_COND_HIBERNATE:
			begin
				state_next.addr    = '0;
				state_next.addr_oe = `BPSC_LEVEL_HIGH;
				state_next.dlo     = '0;
				state_next.dlo_oe  = `BPSC_LEVEL_HIGH;
				state_next.dhi     = '0;
				state_next.dhi_oe  = upper_is_data_i;
				state_next.bclk    = `BPSC_LEVEL_LOW;
				if (state_next.cond == bpsc_pkg::BPSC_COND_SYSRST)
				begin
					state_next.disp    = `BPSC_LEVEL_HIGH;
					state_next.disp_oe = `BPSC_LEVEL_HIGH;
					state_next.boot    = '1;
					state_next.boot_oe = `BPSC_LEVEL_HIGH;
					state_next.strb    = '1;
					state_next.strb_oe = `BPSC_LEVEL_HIGH;
					state_next.ras     = {RAS_W{~state_next.sw_src}};
					state_next.cas     = {2{~state_next.sw_src}};
					state_next.dram_oe = `BPSC_LEVEL_HIGH;
					state_next.rout    = `BPSC_LEVEL_HIGH;
					state_next.rout_oe = `BPSC_LEVEL_HIGH;
				end
				else
				begin
					state_next.disp_oe = `BPSC_LEVEL_LOW;
					state_next.boot_oe = `BPSC_LEVEL_LOW;
					state_next.strb_oe = `BPSC_LEVEL_LOW;
					state_next.rout_oe = `BPSC_LEVEL_LOW;
					state_next.dram_oe = `BPSC_LEVEL_HIGH;
					// Clock-domain reset parks DRAM strobes high, hibernate low.
					state_next.ras = {RAS_W{state_next.cond == bpsc_pkg::BPSC_COND_CLKRST}};
					state_next.cas = {2{state_next.cond == bpsc_pkg::BPSC_COND_CLKRST}};
				end
			end
			bpsc_pkg::BPSC_COND_SUSPEND:
			begin
				state_next.addr    = state_reg.r_addr;
				state_next.addr_oe = `BPSC_LEVEL_HIGH;
				state_next.dlo     = state_reg.r_dlo;
				state_next.dlo_oe  = state_reg.r_doe;
				state_next.dhi     = state_reg.r_dhi;
				state_next.dhi_oe  = state_reg.r_doe | ~upper_is_data_i;
				state_next.disp    = `BPSC_LEVEL_HIGH;
				state_next.disp_oe = `BPSC_LEVEL_HIGH;
				state_next.boot    = '1;
				state_next.boot_oe = `BPSC_LEVEL_HIGH;
				state_next.strb    = '1;
				state_next.strb_oe = `BPSC_LEVEL_HIGH;
				state_next.ras     = '0;
				state_next.cas     = '0;
				state_next.dram_oe = `BPSC_LEVEL_HIGH;
				state_next.bclk    = `BPSC_LEVEL_LOW;
				state_next.rout    = `BPSC_LEVEL_LOW;
				state_next.rout_oe = `BPSC_LEVEL_HIGH;
			end
			bpsc_pkg::BPSC_COND_HOLD:
			begin
				state_next.addr_oe = `BPSC_LEVEL_LOW;
				state_next.dlo_oe  = `BPSC_LEVEL_LOW;
				// Upper half as GPIO keeps its last full-speed state.
				state_next.dhi     = state_reg.r_dhi;
				state_next.dhi_oe  = ~upper_is_data_i & state_reg.r_doe;
				state_next.disp    = `BPSC_LEVEL_HIGH;
				state_next.disp_oe = `BPSC_LEVEL_HIGH;
				state_next.boot    = '1;
				state_next.boot_oe = `BPSC_LEVEL_HIGH;
				state_next.strb_oe = `BPSC_LEVEL_LOW;
				state_next.dram_oe = `BPSC_LEVEL_LOW;
				state_next.bclk    = state_next.hold_from_susp ? `BPSC_LEVEL_LOW
					: core_system_bus_clock_out_i;
				state_next.rout    = core_rst_out_i;
				state_next.rout_oe = `BPSC_LEVEL_HIGH;
			end
			default:
			begin
				state_next.addr    = core_addr_i;
				state_next.addr_oe = `BPSC_LEVEL_HIGH;
				state_next.dlo     = core_dlo_i;
				state_next.dlo_oe  = core_data_oe_i;
				state_next.dhi     = core_dhi_i;
				state_next.dhi_oe  = core_data_oe_i;
				state_next.disp    = core_display_sel_n_i;
				state_next.disp_oe = `BPSC_LEVEL_HIGH;
				state_next.boot    = core_boot_sel_n_i;
				state_next.boot_oe = `BPSC_LEVEL_HIGH;
				state_next.strb    = core_strobes_n_i;
				state_next.strb_oe = `BPSC_LEVEL_HIGH;
				state_next.ras     = core_row_n_i;
				state_next.cas     = core_col_n_i;
				state_next.dram_oe = `BPSC_LEVEL_HIGH;
				state_next.bclk    = core_system_bus_clock_out_i;
				state_next.rout    = core_rst_out_i;
				state_next.rout_oe = `BPSC_LEVEL_HIGH;
			end
		endcase
	end

	// Reset loads the clock-domain reset state but floats upper data; its synchroniser starts armed so the state outlasts reset.
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_reg         <= '0;
			state_reg.sync[0] <= `BPSC_SYNC_ARMED;
			state_reg.held[0] <= `BPSC_LEVEL_HIGH;
			state_reg.cond    <= bpsc_pkg::BPSC_COND_CLKRST;
			state_reg.ras     <= '1;
			state_reg.cas     <= '1;
			state_reg.dram_oe <= 1'b1;
			state_reg.addr_oe <= 1'b1;
			state_reg.dlo_oe  <= 1'b1;
		end
		else
			state_reg <= state_next;
	end

	assign addr_o                    = state_reg.addr;
	assign addr_oe_o                 = state_reg.addr_oe;
	assign dlo_o                     = state_reg.dlo;
	assign dlo_oe_o                  = state_reg.dlo_oe;
	assign dhi_o                     = state_reg.dhi;
	assign dhi_oe_o                  = state_reg.dhi_oe;
	assign display_select_n_o        = state_reg.disp;
	assign display_select_oe_o       = state_reg.disp_oe;
	assign boot_memory_select_n_o    = state_reg.boot;
	assign boot_memory_select_oe_o   = state_reg.boot_oe;
	assign strobes_n_o               = state_reg.strb;
	assign strobes_oe_o              = state_reg.strb_oe;
	assign dram_row_strobe_n_o       = state_reg.ras;
	assign dram_upper_col_strobe_n_o = state_reg.cas[1];
	assign dram_lower_col_strobe_n_o = state_reg.cas[0];
	assign dram_oe_o                 = state_reg.dram_oe;
	assign system_bus_clock_out_o    = state_reg.bclk;
	assign reset_output_o            = state_reg.rout;
	assign reset_output_oe_o         = state_reg.rout_oe;
	assign cond_o                    = state_reg.cond;
endmodule // bpsc_top
`default_nettype wire

// ===== test/bpsc_bus_model.sv
// Address bus as the memories and peripherals see it.
// Assumes no pull resistors: a released bus shows the inverse of its last level.
`default_nettype none
module bpsc_bus_model
(
	input  wire logic        mclk_i,
	input  wire logic [25:0] val_i,
	input  wire logic        oe_i,
	output logic [25:0]      pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [25:0] last_reg;
	always_ff @(posedge mclk_i)
	begin
		if (oe_i)
			last_reg <= val_i;
	end
	assign pin_o = oe_i ? val_i : ~last_reg;
endmodule // bpsc_bus_model
`default_nettype wire

// ===== test/bpsc_chk.sv
// Assertions on the pin levels of bpsc_top for each bus condition.
// Assumes the pins and cond_o are updated on the same mclk_i edge.
`default_nettype none
module bpsc_chk
(
	input wire logic                 mclk_i,
	input wire logic                 rst_n_i,
	input wire logic                 clock_domain_reset_i,
	input wire logic                 watchdog_reset_i,
	input wire logic                 reset_switch_input_i,
	input wire logic                 hibernate_i,
	input wire logic [25:0]          core_addr_i,
	input wire logic [25:0]          addr_o,
	input wire logic                 addr_oe_o,
	input wire logic [15:0]          dlo_o,
	input wire logic                 dlo_oe_o,
	input wire logic [15:0]          dhi_o,
	input wire logic                 dhi_oe_o,
	input wire logic                 display_select_n_o,
	input wire logic                 display_select_oe_o,
	input wire logic [3:0]           boot_memory_select_n_o,
	input wire logic                 boot_memory_select_oe_o,
	input wire logic [5:0]           strobes_n_o,
	input wire logic                 strobes_oe_o,
	input wire logic [3:0]           dram_row_strobe_n_o,
	input wire logic                 dram_upper_col_strobe_n_o,
	input wire logic                 dram_lower_col_strobe_n_o,
	input wire logic                 dram_oe_o,
	input wire logic                 system_bus_clock_out_o,
	input wire logic                 reset_output_o,
	input wire logic                 reset_output_oe_o,
	input wire bpsc_pkg::bpsc_cond_t cond_o
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic c_nrm = cond_o == bpsc_pkg::BPSC_COND_NORMAL;
	wire logic c_clk = cond_o == bpsc_pkg::BPSC_COND_CLKRST;
	wire logic c_sys = cond_o == bpsc_pkg::BPSC_COND_SYSRST;
	wire logic c_sus = cond_o == bpsc_pkg::BPSC_COND_SUSPEND;
	wire logic c_hib = cond_o == bpsc_pkg::BPSC_COND_HIBERNATE;
	wire logic c_hld = cond_o == bpsc_pkg::BPSC_COND_HOLD;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	a_zero_drive: assert property (
		(c_clk || c_sys || c_hib) |-> addr_oe_o && addr_o == 26'h0 && dlo_oe_o && dlo_o == 16'h0)
		else $error("address or low data not driven to zero");
	a_hold_float: assert property (
		c_hld |-> !(addr_oe_o || dlo_oe_o || strobes_oe_o || dram_oe_o))
		else $error("bus still driven during hold");
	a_susp_keep: assert property (
		c_sus && $past(c_sus) |-> $stable(addr_o) && $stable(dlo_o))
		else $error("retained bus value moved in suspend");
	a_select_lvl: assert property (
		(c_sys || c_sus || c_hld) |-> display_select_oe_o && display_select_n_o
			&& boot_memory_select_oe_o && &boot_memory_select_n_o)
		else $error("chip select not held high");
	a_float_set: assert property (
		(c_clk || c_hib) |-> !(display_select_oe_o || boot_memory_select_oe_o
			|| strobes_oe_o || reset_output_oe_o))
		else $error("pin not floated");
	a_sleep_lvl: assert property (
		(c_sys || c_sus) |-> strobes_oe_o && &strobes_n_o && reset_output_oe_o
			&& reset_output_o == c_sys)
		else $error("strobe or reset output level wrong");
	a_dram_low: assert property (
		(c_sus || c_hib) |-> dram_oe_o && dram_row_strobe_n_o == 4'h0)
		else $error("row strobes not low");
	a_clk_low: assert property (
		(c_clk || c_sys || c_sus || c_hib) |-> !system_bus_clock_out_o)
		else $error("bus clock not low");
	a_cond_lat: assert property (
		$rose(hibernate_i) ##0 (hibernate_i && !clock_domain_reset_i && !watchdog_reset_i
			&& !reset_switch_input_i) [*5] |-> c_hib)
		else $error("hibernate not taken in four edges");
	a_core_pass: assert property (
		c_nrm && $past(c_nrm) |-> addr_o == $past(core_addr_i))
		else $error("address not passed through");
	a_col_level: assert property (
		(c_clk || c_sys || c_sus || c_hib) |-> dram_oe_o
			&& dram_row_strobe_n_o == {4{dram_upper_col_strobe_n_o}}
			&& dram_lower_col_strobe_n_o == dram_upper_col_strobe_n_o
			&& (c_sys || dram_upper_col_strobe_n_o == c_clk))
		else $error("column strobes differ from condition level");
	a_upper_zero: assert property (
		(c_clk || c_sys || c_hib) && dhi_oe_o |-> dhi_o == 16'h0)
		else $error("upper data half not driven to zero");
	c_hold_seen: cover property (c_hld);
	c_susp_seen: cover property (c_sus);
	c_self_ref: cover property (c_sys && dram_row_strobe_n_o == 4'h0);
endmodule // bpsc_chk
bind bpsc_top bpsc_chk u_bpsc_chk (.*);
`default_nettype wire

// ===== test/tb.sv
// Bench for bpsc_top: walks through bus conditions and checks the pin states.
// Assumes bpsc_chk is bound to the design and bpsc_bus_model sits on the bus.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [5:0] soe_m = 6'h2d;
	localparam logic [5:0] toe_m = 6'h0d;
	logic mclk_i, rst_n_i, clock_domain_reset_i, watchdog_reset_i, reset_switch_input_i;
	logic suspend_i, hibernate_i, power_down_timer_i, bus_hold_i, upper_is_data_i;
	logic core_data_oe_i, core_display_sel_n_i, core_system_bus_clock_out_i, core_rst_out_i, last_oe;
	logic [25:0] core_addr_i, addr_o, bus_addr, last_a;
	logic [15:0] core_dlo_i, core_dhi_i, dlo_o, dhi_o;
	logic [3:0] core_boot_sel_n_i, core_row_n_i, boot_memory_select_n_o, dram_row_strobe_n_o;
	logic [5:0] core_strobes_n_i, strobes_n_o;
	logic [1:0] core_col_n_i;
	logic addr_oe_o, dlo_oe_o, dhi_oe_o, display_select_n_o, display_select_oe_o;
	logic boot_memory_select_oe_o, strobes_oe_o, dram_upper_col_strobe_n_o, dram_oe_o;
	logic dram_lower_col_strobe_n_o, system_bus_clock_out_o, reset_output_o, reset_output_oe_o;
	bpsc_pkg::bpsc_cond_t cond_o, cur, seen;
	logic [40:0] q[$];
	int error_cnt, compares;
	int plan[7] = '{0, 3, 5, 0, 5, 4, 1};
	bpsc_top u_bpsc_top (.*);
	bpsc_bus_model u_bpsc_bus_model (.mclk_i, .val_i(addr_o), .oe_i(addr_oe_o), .pin_o(bus_addr));
	initial
	begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end
	always @(negedge mclk_i) core_system_bus_clock_out_i <= ~core_system_bus_clock_out_i;
	task automatic fail(string m);
		error_cnt++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic cmp_pins(logic [40:0] e, logic [40:0] a);
		compares++;
		if (a !== e) fail($sformatf("pins %h expected %h", a, e));
	endtask
	task automatic cmp_clk(logic e, logic a);
		compares++;
		if (a !== e) fail("bus clock level");
	endtask
	task automatic print_verdict();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Float pins are masked so that their undriven value never enters a compare.
	function automatic logic [40:0] snap();
		return {cond_o, addr_oe_o, addr_oe_o ? bus_addr : 26'h0, dlo_oe_o, dhi_oe_o,
			display_select_oe_o, display_select_n_o & display_select_oe_o, strobes_oe_o,
			&strobes_n_o & strobes_oe_o, dram_oe_o, dram_row_strobe_n_o[0] & dram_oe_o,
			reset_output_oe_o, reset_output_o & reset_output_oe_o,
			system_bus_clock_out_o & !(cond_o inside {bpsc_pkg::BPSC_COND_NORMAL,
			bpsc_pkg::BPSC_COND_HOLD})};
	endfunction
	function automatic logic [40:0] want(int i);
		logic n, p;
		n = i == 0;
		p = i == 3;
		return {3'(i), i != 5, n ? core_addr_i : p ? last_a : 26'h0,
			n ? core_data_oe_i : p ? last_oe : i != 5,
			n ? core_data_oe_i : p ? last_oe : i != 5 && upper_is_data_i,
			soe_m[i], n ? core_display_sel_n_i : soe_m[i], toe_m[i],
			n ? &core_strobes_n_i : toe_m[i], i != 5,
			n ? core_row_n_i[0] : i == 1 || (i == 2 && !reset_switch_input_i),
			soe_m[i], (n || i == 5) ? core_rst_out_i : i == 2, 1'b0};
	endfunction
	task automatic rnd(logic keep);
		logic [95:0] r;
		r = {$urandom, $urandom, $urandom};
		{core_addr_i, core_dlo_i, core_dhi_i, core_boot_sel_n_i, core_strobes_n_i,
			core_row_n_i, core_col_n_i, core_data_oe_i, core_display_sel_n_i,
			core_rst_out_i} = r[76:0];
		if (keep)
		begin
			last_a = core_addr_i;
			last_oe = core_data_oe_i;
		end
	endtask
	task automatic go(int i);
		int n;
		logic v;
		@(negedge mclk_i);
		v = 1'($urandom);
		rnd(cur == bpsc_pkg::BPSC_COND_NORMAL || i == 0);
		clock_domain_reset_i = i == 1;
		watchdog_reset_i = i == 2 && !v;
		reset_switch_input_i = i == 2 && v;
		suspend_i = i == 3;
		hibernate_i = i == 4 && !v;
		power_down_timer_i = i == 4 && v;
		bus_hold_i = i == 5;
		upper_is_data_i = !(i == 4 && v);
		q.push_back(want(i));
		for (n = 0; n < 12 && cond_o !== 3'(i); n++)
			@(negedge mclk_i);
		if (n == 12)
		begin
			fail("condition not reached");
			print_verdict();
		end
		repeat (2)
		begin
			@(negedge mclk_i);
			if (i == 5)
				cmp_clk(cur != bpsc_pkg::BPSC_COND_SUSPEND && core_system_bus_clock_out_i, system_bus_clock_out_o);
		end
		cur = cond_o;
	endtask
	always @(negedge mclk_i)
	begin
		if (rst_n_i === 1'b1 && cond_o !== seen)
		begin
			seen = cond_o;
			if (q.size() == 0)
				fail("unexpected condition change");
			else
				cmp_pins(q.pop_front(), snap());
		end
	end
	initial
	begin
		error_cnt = 0;
		compares = 0;
		void'($urandom(32'hd349));
		cur = bpsc_pkg::BPSC_COND_CLKRST;
		seen = cur;
		rst_n_i = 1'b0;
		core_system_bus_clock_out_i = 1'b0;
		{clock_domain_reset_i, watchdog_reset_i, reset_switch_input_i, suspend_i} = 4'h0;
		{hibernate_i, power_down_timer_i, bus_hold_i, upper_is_data_i} = 4'h1;
		rnd(1'b0);
		repeat (6) @(posedge mclk_i);
		@(negedge mclk_i);
		rst_n_i = 1'b1;
		foreach (plan[k]) go(plan[k]);
		repeat (40) go((int'(cur) + 1 + $urandom % 5) % 6);
		print_verdict();
	end
endmodule // tb
`default_nettype wire
